// ---- src/urx_pkg.sv ----
// Shared constants and types of the asynchronous serial receiver
`default_nettype none

package urx_pkg;

   // ************************************************************
   // Register bus
   // ************************************************************
   localparam int URX_AW = 8;
   localparam int URX_DW = 8;
   localparam logic [7:0] URX_OFS_INT_FLAGS = 8'h0C;
   localparam logic [7:0] URX_OFS_INT_CLEAR = 8'h0D;
   localparam logic [7:0] URX_OFS_INT_ENABLES = 8'h8C;
   localparam logic [7:0] URX_OFS_STATUS_CTRL = 8'h10;
   localparam logic [7:0] URX_OFS_DATA_BUF = 8'h11;
   localparam logic [7:0] URX_OFS_BAUD_CTRL = 8'h12;
   localparam logic [7:0] URX_OFS_BAUD_DIV = 8'h13;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] URX_RST_INT_FLAGS = 8'h00;
   localparam logic [7:0] URX_RST_INT_ENABLES = 8'h00;
   localparam logic [7:0] URX_RST_BAUD_DIV = 8'h00;
   localparam logic URX_RST_RX_CONTINUOUS_ENABLE = 1'b0;
   localparam logic URX_RST_RX9EN = 1'b0;
   localparam logic URX_RST_HS = 1'b0;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int URX_FLG_READY_BIT = 5;
   localparam int URX_FLG_FRAMING_ERROR_BIT = 2;
   localparam int URX_FLG_OVR_BIT = 1;
   localparam int URX_STC_RX9EN_BIT = 6;
   localparam int URX_STC_RX_CONTINUOUS_ENABLE_BIT = 4;
   localparam int URX_STC_FRAMING_ERROR_BIT = 2;
   localparam int URX_STC_OVERRUN_ERROR_BIT = 1;
   localparam int URX_STC_RX_NINTH_BIT_BIT = 0;
   localparam int URX_BCTL_HS_BIT = 2;
   localparam int URX_ENT_W = 10;
   localparam int URX_ENT_FRAMING_ERROR_BIT = 9;
   localparam int URX_ENT_NINTH_BIT = 8;

   // ************************************************************
   // Timing counts
   // ************************************************************
   localparam int URX_OVERSAMPLE = 16;
   localparam int URX_LOW_SPEED_FACTOR = 64;
   localparam int URX_HIGH_SPEED_FACTOR = 16;
   localparam logic [3:0] URX_MID_TICK = 4'(URX_OVERSAMPLE / 2 - 1);
   localparam logic [3:0] URX_LAST_TICK = 4'(URX_OVERSAMPLE - 1);
   localparam logic [3:0] URX_LAST_BIT8 = 4'h7;
   localparam logic [3:0] URX_LAST_BIT9 = 4'h8;
   localparam int URX_FIFO_DEPTH = 2;

   typedef enum logic [1:0] {URX_IDLE, URX_START, URX_DATA, URX_STOP} urx_state_e;

endpackage

`default_nettype wire

// ---- src/urx_baud.sv ----
// Oversampling tick generator for the receiver
`default_nettype none

module urx_baud
   import urx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Setup
   input wire logic run,
   input wire logic high_speed_baud_select,
   input wire logic [7:0] baud_divisor,
   // Tick at sixteen times the bit rate
   output logic tick16
);

   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } urx_baud_s;

   urx_baud_s q;
   urx_baud_s d;
   logic [9:0] reload;

   // Low speed: 64*(n+1) clocks per bit is 4*(n+1) per tick; high speed: n+1 per tick
   always_comb begin
      reload = high_speed_baud_select ? {2'h0, baud_divisor} : {baud_divisor, 2'h3};
      d = q;
      d.tick = 1'b0;
      if (!run) begin
         d.cnt = reload;
      end else if (q.cnt == 10'h000) begin
         d.cnt = reload;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt - 10'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign tick16 = q.tick;

endmodule // urx_baud

`default_nettype wire

// ---- src/urx_fifo.sv ----
// First-in first-out store for received words with their status bits
`default_nettype none

module urx_fifo
   import urx_pkg::*;
#(
   parameter int WIDTH = URX_ENT_W,
   parameter int DEPTH = URX_FIFO_DEPTH
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Fill side
   input wire logic push,
   input wire logic [WIDTH-1:0] din,
   output logic full,
   // Drain side
   input wire logic pop,
   output logic [WIDTH-1:0] dout,
   output logic empty
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [CW-1:0] count;
   } urx_fifo_s;

   urx_fifo_s q;
   urx_fifo_s d;
   logic do_push;
   logic do_pop;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_comb begin
      d = q;
      do_pop = pop && (q.count != '0);
      do_push = push && (q.count != CW'(DEPTH));
      if (do_push) begin
         d.mem[q.wptr] = din;
         d.wptr = bump(q.wptr);
      end
      if (do_pop) begin
         d.rptr = bump(q.rptr);
      end
      if (do_push && !do_pop) begin
         d.count = q.count + CW'(1);
      end else if (do_pop && !do_push) begin
         d.count = q.count - CW'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign full = (q.count == CW'(DEPTH));
   assign empty = (q.count == '0);
   assign dout = q.mem[q.rptr];

endmodule // urx_fifo

`default_nettype wire

// ---- src/urx_receiver.sv ----
// Asynchronous serial receiver with two-word receive buffer and status
// Notes on behaviour
// R01 - The line is examined at sixteen ticks per bit while the word shifter moves once per bit.
// R02 - Frames are taken only while the continuous receive enable bit is set.
// R03 - After the stop bit is sampled the assembled word goes to the receive buffer if it has room.
// R04 - A word arriving in the buffer raises the receive-ready flag at bit 5 of the flag register.
// R05 - The interrupt follows the ready flag only while enable bit 5 is set; the flag sets regardless.
// R06 - The ready flag cannot be written and drops once reads have emptied the buffer.
// R07 - The buffer holds two words in order while a third may still be shifting in.
// R08 - A stop bit found with the buffer full sets the overrun bit and drops the shifted word.
// R09 - Software clears overrun by clearing and then setting the continuous receive enable bit.
// R10 - While overrun is set no word moves from the shifter to the buffer.
// R11 - A stop bit sampled low marks the word with a framing error.
// R12 - Framing error and ninth bit travel with each word and change when the data is read.
// R13 - Software reads the status register before the data buffer to keep that word's status.
// R14 - In low-speed mode the bit rate is the clock over 64 times the divisor plus one.
// R15 - In high-speed mode the bit rate is the clock over 16 times the divisor plus one.
// R16 - A frame is a low start bit, eight or nine data bits LSB first and a high stop bit.
// R17 - Clearing the enable drops any partial frame and the next start bit begins afresh.
//
// Chosen here: the plain strobed port.
`default_nettype none

module urx_receiver
   import urx_pkg::*;
(
   // Clock, reset and enable
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Serial line
   input wire logic serial_in_pin,
   // Register port
   input wire logic [URX_AW-1:0] addr,
   input wire logic [URX_DW-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [URX_DW-1:0] rd_data,
   // Interrupt
   output logic irq
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [2:0] sync;
      logic rx;
      urx_state_e st;
      logic [3:0] tick;
      logic [3:0] nbit;
      logic [8:0] shift;
      logic rx_continuous_enable;
      logic rx9en;
      logic hs;
      logic [7:0] div;
      logic overrun_error;
      logic [7:0] evt;
      logic [7:0] ien;
      logic [7:0] rdat;
      logic irq;
   } urx_core_s;

   urx_core_s q;
   urx_core_s d;

   logic tick16;
   logic push;
   logic pop;
   logic fifo_full;
   logic fifo_empty;
   logic [URX_ENT_W-1:0] ent_in;
   logic [URX_ENT_W-1:0] ent_out;
   logic [7:0] flags_v;
   logic [7:0] status_v;
   logic [7:0] bctl_v;
   logic [3:0] last_bit;

   // ************************************************************
   // Bit-rate ticks
   // ************************************************************
   // Restarting the divider with the enable keeps tick phase repeatable
   urx_baud u_baud (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .run(q.rx_continuous_enable),
      .high_speed_baud_select(q.hs),
      .baud_divisor(q.div),
      .tick16(tick16)
   ); // R14 R15

   // ************************************************************
   // Receive buffer
   // ************************************************************
   urx_fifo #(
      .WIDTH(URX_ENT_W),
      .DEPTH(URX_FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .push(push),
      .din(ent_in),
      .full(fifo_full),
      .pop(pop),
      .dout(ent_out),
      .empty(fifo_empty)
   ); // R07

   // ************************************************************
   // Read views
   // ************************************************************
   always_comb begin
      flags_v = q.evt;
      flags_v[URX_FLG_READY_BIT] = !fifo_empty; // R04 R06
      status_v = 8'h00;
      status_v[URX_STC_RX9EN_BIT] = q.rx9en;
      status_v[URX_STC_RX_CONTINUOUS_ENABLE_BIT] = q.rx_continuous_enable;
      status_v[URX_STC_OVERRUN_ERROR_BIT] = q.overrun_error;
      // Status of the word at the head of the buffer
      status_v[URX_STC_FRAMING_ERROR_BIT] = !fifo_empty && ent_out[URX_ENT_FRAMING_ERROR_BIT]; // R12
      status_v[URX_STC_RX_NINTH_BIT_BIT] = !fifo_empty && ent_out[URX_ENT_NINTH_BIT]; // R12
      bctl_v = 8'h00;
      bctl_v[URX_BCTL_HS_BIT] = q.hs;
      last_bit = q.rx9en ? URX_LAST_BIT9 : URX_LAST_BIT8;
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;
      push = 1'b0;
      pop = 1'b0;
      ent_in = '0;

      // Three-stage line synchroniser; a change counts once stages two and three agree
      d.sync = {q.sync[1:0], serial_in_pin};
      if (q.sync[1] == q.sync[2]) begin
         d.rx = q.sync[2];
      end

      // Register writes
      if (wr_en) begin
         if (addr == URX_OFS_INT_CLEAR) begin
            d.evt = q.evt & ~wr_data;
         end else if (addr == URX_OFS_INT_ENABLES) begin
            d.ien = wr_data;
         end else if (addr == URX_OFS_STATUS_CTRL) begin
            d.rx9en = wr_data[URX_STC_RX9EN_BIT];
            d.rx_continuous_enable = wr_data[URX_STC_RX_CONTINUOUS_ENABLE_BIT];
         end else if (addr == URX_OFS_BAUD_CTRL) begin
            d.hs = wr_data[URX_BCTL_HS_BIT];
         end else if (addr == URX_OFS_BAUD_DIV) begin
            d.div = wr_data;
         end
      end

      // Register reads; data stands one cycle after the strobe
      d.rdat = 8'h00;
      if (rd_en) begin
         if (addr == URX_OFS_INT_FLAGS) begin
            d.rdat = flags_v;
         end else if (addr == URX_OFS_INT_ENABLES) begin
            d.rdat = q.ien;
         end else if (addr == URX_OFS_STATUS_CTRL) begin
            d.rdat = status_v;
         end else if (addr == URX_OFS_DATA_BUF) begin
            d.rdat = fifo_empty ? 8'h00 : ent_out[7:0];
            pop = !fifo_empty; // R06 R12
         end else if (addr == URX_OFS_BAUD_CTRL) begin
            d.rdat = bctl_v;
         end else if (addr == URX_OFS_BAUD_DIV) begin
            d.rdat = q.div;
         end
      end

      // Receive engine
      if (!q.rx_continuous_enable) begin
         // Disabled: drop any partial frame and the overrun condition
         d.st = URX_IDLE; // R02 R17
         d.tick = 4'h0;
         d.overrun_error = 1'b0; // R09
      end else if (tick16) begin // R01
         case (q.st)
            URX_IDLE: begin
               d.tick = 4'h0;
               if (!q.rx) begin
                  d.st = URX_START; // R16
               end
            end
            URX_START: begin
               d.tick = q.tick + 4'h1;
               if (q.tick == URX_MID_TICK) begin
                  d.tick = 4'h0;
                  d.nbit = 4'h0;
                  // A start bit that is gone by mid-bit was a glitch
                  d.st = q.rx ? URX_IDLE : URX_DATA;
               end
            end
            URX_DATA: begin
               d.tick = q.tick + 4'h1;
               if (q.tick == URX_LAST_TICK) begin
                  d.tick = 4'h0;
                  d.nbit = q.nbit + 4'h1;
                  // LSB first; eight-bit frames keep the ninth position clear
                  if (q.rx9en) begin
                     d.shift = {q.rx, q.shift[8:1]}; // R16
                  end else begin
                     d.shift = {1'b0, q.rx, q.shift[7:1]}; // R16
                  end
                  if (q.nbit == last_bit) begin
                     d.st = URX_STOP;
                  end
               end
            end
            URX_STOP: begin
               d.tick = q.tick + 4'h1;
               if (q.tick == URX_LAST_TICK) begin
                  d.tick = 4'h0;
                  // Back to idle at mid stop so a quick next start bit is not missed
                  d.st = URX_IDLE;
                  if (q.overrun_error) begin
                     push = 1'b0; // R10
                  end else if (fifo_full) begin
                     d.overrun_error = 1'b1; // R08
                     d.evt[URX_FLG_OVR_BIT] = 1'b1; // R08
                  end else begin
                     push = 1'b1; // R03
                     ent_in = {!q.rx, q.shift}; // R11 R12
                     if (!q.rx) begin
                        d.evt[URX_FLG_FRAMING_ERROR_BIT] = 1'b1; // R11
                     end
                  end
               end
            end
            default: begin
               d.st = URX_IDLE;
            end
         endcase
      end

      // Ready bit is a level of the buffer, never held as a sticky bit
      d.evt[URX_FLG_READY_BIT] = 1'b0; // R06
      d.irq = |(flags_v & q.ien); // R05
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.sync <= 3'h7;
         q.rx <= 1'b1;
         q.st <= URX_IDLE;
         q.rx_continuous_enable <= URX_RST_RX_CONTINUOUS_ENABLE;
         q.rx9en <= URX_RST_RX9EN;
         q.hs <= URX_RST_HS;
         q.div <= URX_RST_BAUD_DIV;
         q.evt <= URX_RST_INT_FLAGS;
         q.ien <= URX_RST_INT_ENABLES;
      end else if (ce) begin
         q <= d;
      end
   end

   assign rd_data = q.rdat;
   assign irq = q.irq;

endmodule // urx_receiver

`default_nettype wire

// ---- bench/urx_line_model.sv ----
// Remote asynchronous transmitter driving the receiver's serial line
`default_nettype none

module urx_line_model
(
   // Clock
   input wire logic ref_clk,
   // Serial line, idle high
   output logic line
);
   timeunit 1ns;
   timeprecision 1ps;

   initial line = 1'b1;

   // A low stop level fakes a broken frame; the line returns high afterwards
   task automatic send(input logic [8:0] d, input int nbits, input logic stop_lvl,
                       input int bclk);
      @(posedge ref_clk);
      line <= 1'b0;
      repeat (bclk) @(posedge ref_clk);
      for (int i = 0; i < nbits; i++) begin
         line <= d[i];
         repeat (bclk) @(posedge ref_clk);
      end
      line <= stop_lvl;
      repeat (bclk) @(posedge ref_clk);
      line <= 1'b1;
   endtask
endmodule // urx_line_model

`default_nettype wire

// ---- bench/urx_receiver_sva.sv ----
// Concurrent checks on the receiver's register port and interrupt
`default_nettype none

module urx_receiver_sva
   import urx_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Serial line
   input wire logic serial_in_pin,
   // Register port
   input wire logic [URX_AW-1:0] addr,
   input wire logic [URX_DW-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [URX_DW-1:0] rd_data,
   // Interrupt
   input wire logic irq
);
   // ****************
   // Shadow registers
   // ****************
   logic [7:0] en_r;
   logic [7:0] ctl_r;
   logic [7:0] bctl_r;
   logic [7:0] div_r;
   logic mapped;
   logic rd_ok;

   assign mapped = addr inside {URX_OFS_INT_FLAGS, URX_OFS_INT_CLEAR, URX_OFS_INT_ENABLES,
      URX_OFS_STATUS_CTRL, URX_OFS_DATA_BUF, URX_OFS_BAUD_CTRL, URX_OFS_BAUD_DIV};
   assign rd_ok = rd_en && ce;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         en_r <= 8'h00;
         ctl_r <= 8'h00;
         bctl_r <= 8'h00;
         div_r <= 8'h00;
      end else if (ce && wr_en) begin
         if (addr == URX_OFS_INT_ENABLES) en_r <= wr_data;
         if (addr == URX_OFS_STATUS_CTRL) ctl_r <= wr_data & 8'h50;
         if (addr == URX_OFS_BAUD_CTRL) bctl_r <= wr_data & 8'h04;
         if (addr == URX_OFS_BAUD_DIV) div_r <= wr_data;
      end
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // ****************
   // Assertions
   // ****************
   a_rdata_idle: assert property ($past(ce) && !$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (rd_ok && !mapped |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_flags_layout: assert property (rd_ok && addr == URX_OFS_INT_FLAGS |=>
      (rd_data & 8'hD9) == 8'h00) else $error("flag register holds unused bits");
   a_enables_rw: assert property (rd_ok && addr == URX_OFS_INT_ENABLES |=>
      rd_data == $past(en_r)) else $error("enable register readback wrong");
   a_ctrl_rw: assert property (rd_ok && addr == URX_OFS_STATUS_CTRL |=>
      (rd_data & 8'h50) == $past(ctl_r)) else $error("control bits readback wrong");
   a_overrun_reset: assert property (rd_ok && addr == URX_OFS_STATUS_CTRL && !ctl_r[4]
      && !$past(ctl_r[4]) |=> !rd_data[1]) else $error("overrun kept while disabled");
   a_irq_masked: assert property ((en_r & 8'h26) == 8'h00
      && ($past(en_r) & 8'h26) == 8'h00 |-> !irq) else $error("interrupt while masked");
   a_baud_rw: assert property (rd_ok && addr == URX_OFS_BAUD_DIV |=>
      rd_data == $past(div_r)) else $error("divisor readback wrong");
   a_speed_rw: assert property (rd_ok && addr == URX_OFS_BAUD_CTRL |=>
      (rd_data & 8'h04) == $past(bctl_r)) else $error("speed select readback wrong");

   c_irq: cover property ($rose(irq));
   c_overrun: cover property (rd_ok && addr == URX_OFS_STATUS_CTRL ##1 rd_data[1]);
   c_framing: cover property (rd_ok && addr == URX_OFS_STATUS_CTRL ##1 rd_data[2]);
endmodule // urx_receiver_sva

`default_nettype wire

// ---- bench/urx_receiver_tb.sv ----
// Self-checking bench of the asynchronous serial receiver
`default_nettype none

module urx_receiver_tb
   import urx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [URX_AW-1:0] addr = 8'h00;
   logic [URX_DW-1:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic ce = 1'b1;
   logic [URX_DW-1:0] rd_data;
   logic irq;
   logic line;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;

   always #5 ref_clk = ~ref_clk;

   urx_line_model i_line (.ref_clk(ref_clk), .line(line));

   // Clock enable drops only in the freeze check of the register scenario
   urx_receiver i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .serial_in_pin(line),
      .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .irq(irq));

   // ****************
   // Shared tasks
   // ****************
   task automatic complete_run();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data & m, e);
   endtask

   task automatic snd(input logic [8:0] d, input int nb, input logic stp, input int bclk);
      i_line.send(d, nb, stp, bclk);
      repeat (8) @(posedge ref_clk);
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_regs();
      rdc(URX_OFS_INT_FLAGS, 8'hFF, 8'h00);
      rdc(URX_OFS_INT_ENABLES, 8'hFF, 8'h00);
      wr(URX_OFS_INT_FLAGS, 8'hFF);
      rdc(URX_OFS_INT_FLAGS, 8'hFF, 8'h00);
      wr(URX_OFS_INT_ENABLES, 8'h20);
      rdc(URX_OFS_INT_ENABLES, 8'hFF, 8'h20);
      wr(URX_OFS_INT_ENABLES, 8'h00);
      rdc(8'h40, 8'hFF, 8'h00);
      // A write while the clock enable is low must not land
      @(posedge ref_clk);
      ce <= 1'b0;
      wr(URX_OFS_BAUD_DIV, 8'h5A);
      ce <= 1'b1;
      rdc(URX_OFS_BAUD_DIV, 8'hFF, 8'h00);
      wr(URX_OFS_BAUD_CTRL, 8'h04);
      snd(9'h055, 8, 1'b1, 16);
      rdc(URX_OFS_INT_FLAGS, 8'h20, 8'h00);
   endtask

   task automatic t_basic();
      wr(URX_OFS_STATUS_CTRL, 8'h10);
      snd(9'h0A5, 8, 1'b1, 16);
      rdc(URX_OFS_INT_FLAGS, 8'h20, 8'h20);
      chk({7'h00, irq}, 8'h00);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'hA5);
      rdc(URX_OFS_INT_FLAGS, 8'h20, 8'h00);
   endtask

   task automatic t_irq();
      wr(URX_OFS_INT_ENABLES, 8'h20);
      snd(9'h03C, 8, 1'b1, 16);
      chk({7'h00, irq}, 8'h01);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h3C);
      repeat (3) @(posedge ref_clk);
      chk({7'h00, irq}, 8'h00);
      wr(URX_OFS_INT_ENABLES, 8'h00);
   endtask

   task automatic t_overrun();
      i_line.send(9'h011, 8, 1'b1, 16);
      i_line.send(9'h022, 8, 1'b1, 16);
      snd(9'h033, 8, 1'b1, 16);
      rdc(URX_OFS_STATUS_CTRL, 8'h02, 8'h02);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h11);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h22);
      rdc(URX_OFS_INT_FLAGS, 8'h22, 8'h02);
      snd(9'h044, 8, 1'b1, 16);
      rdc(URX_OFS_INT_FLAGS, 8'h20, 8'h00);
      wr(URX_OFS_INT_CLEAR, 8'h06);
      rdc(URX_OFS_INT_FLAGS, 8'h06, 8'h00);
      wr(URX_OFS_STATUS_CTRL, 8'h00);
      rdc(URX_OFS_STATUS_CTRL, 8'h12, 8'h00);
      wr(URX_OFS_STATUS_CTRL, 8'h10);
      rdc(URX_OFS_STATUS_CTRL, 8'h02, 8'h00);
      snd(9'h055, 8, 1'b1, 16);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h55);
   endtask

   task automatic t_ferr9();
      wr(URX_OFS_STATUS_CTRL, 8'h50);
      i_line.send(9'h15A, 9, 1'b1, 16);
      snd(9'h0C3, 9, 1'b0, 16);
      rdc(URX_OFS_STATUS_CTRL, 8'h05, 8'h01);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h5A);
      rdc(URX_OFS_STATUS_CTRL, 8'h05, 8'h04);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'hC3);
      rdc(URX_OFS_INT_FLAGS, 8'h04, 8'h04);
      wr(URX_OFS_INT_CLEAR, 8'h04);
   endtask

   // All-ones data keeps the tail of the dropped frame from faking a start
   task automatic t_abort();
      fork
         snd(9'h0FF, 8, 1'b1, 16);
         begin
            repeat (40) @(posedge ref_clk);
            wr(URX_OFS_STATUS_CTRL, 8'h00);
            wr(URX_OFS_STATUS_CTRL, 8'h10);
         end
      join
      rdc(URX_OFS_INT_FLAGS, 8'h20, 8'h00);
      snd(9'h081, 8, 1'b1, 16);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h81);
   endtask

   task automatic t_speeds();
      wr(URX_OFS_BAUD_CTRL, 8'h00);
      wr(URX_OFS_BAUD_DIV, 8'h01);
      rdc(URX_OFS_BAUD_DIV, 8'hFF, 8'h01);
      snd(9'h096, 8, 1'b1, 128);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h96);
      wr(URX_OFS_BAUD_CTRL, 8'h04);
      snd(9'h069, 8, 1'b1, 32);
      rdc(URX_OFS_DATA_BUF, 8'hFF, 8'h69);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_regs();
      t_basic();
      t_irq();
      t_overrun();
      t_ferr9();
      t_abort();
      t_speeds();
      complete_run();
   end
endmodule // urx_receiver_tb

bind urx_receiver urx_receiver_sva i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
   .serial_in_pin(serial_in_pin), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
   .rd_en(rd_en), .rd_data(rd_data), .irq(irq));

`default_nettype wire
